// ### inc/caw_pkg.sv
package caw_pkg;

    localparam int NUM_CH = 5;
    localparam int WD_CH = 4;

    // special function register addresses
    localparam logic [7:0] ADDR_CONTROL = 8'hD8;
    localparam logic [7:0] ADDR_MODE = 8'hD9;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'hF9;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hFA;
    localparam logic [NUM_CH-1:0][7:0] ADDR_CH_MODE = {8'hDE, 8'hDD, 8'hDC, 8'hDB, 8'hDA};
    localparam logic [NUM_CH-1:0][7:0] ADDR_CH_CMP_LOW = {8'hED, 8'hE1, 8'hEB, 8'hE9, 8'hFB};
    localparam logic [NUM_CH-1:0][7:0] ADDR_CH_CMP_HIGH = {8'hEE, 8'hE2, 8'hEC, 8'hEA, 8'hFC};

    // control register fields
    localparam int CTL_OVF_FLAG = 7;
    localparam int CTL_RUN = 6;

    // array mode register fields
    localparam int MD_IDLE_SUSPEND = 7;
    localparam int MD_WD_ENABLE = 6;
    localparam int MD_WD_LOCK = 5;
    localparam int MD_TB_LSB = 1;
    localparam int MD_OVF_IRQ_EN = 0;

    // channel mode register fields
    localparam int CM_WIDE_PWM = 7;
    localparam int CM_CMP_EN = 6;
    localparam int CM_MATCH_EN = 3;
    localparam int CM_IRQ_EN = 0;

    localparam logic [7:0] MODE_RESET = 8'h40;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;

    // timebase selections
    localparam logic [2:0] TB_DIV12 = 3'h0;
    localparam logic [2:0] TB_DIV4 = 3'h1;
    localparam logic [2:0] TB_TMR0 = 3'h2;
    localparam logic [2:0] TB_EXT_PIN = 3'h3;
    localparam logic [2:0] TB_SYSCLK = 3'h4;
    localparam logic [2:0] TB_EXT_OSC = 3'h5;

    localparam int PRESCALE_SLOW = 12;
    localparam int PRESCALE_FAST = 4;
    localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_SLOW - 1);
    localparam logic [1:0] FAST_LAST = 2'(PRESCALE_FAST - 1);

    // default timeout: 256 array ticks at sysclk/12
    localparam int DEFAULT_TIMEOUT_TICKS = 256;
    localparam int DEFAULT_TIMEOUT_CYCLES = DEFAULT_TIMEOUT_TICKS * PRESCALE_SLOW;

endpackage

// ### hdl/caw_timebase.sv
`timescale 1ns/1ps
module caw_timebase (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] sel_i,
    input wire logic tmr0_ovf_i,
    input wire logic ext_pin_i,
    input wire logic ext_osc_tick_i,
    output logic tick_o
);
    typedef struct packed {
        logic [3:0] pre;
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } caw_tb_state_t;

    caw_tb_state_t st_r;
    caw_tb_state_t st_nxt;
    logic pin_fall;

    always_comb begin
        st_nxt = st_r;
        st_nxt.pre = (st_r.pre == caw_pkg::PRESCALE_LAST) ? 4'h0 : st_r.pre + 4'h1;
        st_nxt.s1 = ext_pin_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // only a level on which stages two and three agree is accepted
        pin_fall = 1'b0;
        if (st_r.s2 == st_r.s3 && st_r.s3 != st_r.lvl) begin
            st_nxt.lvl = st_r.s3;
            pin_fall = st_r.lvl;
        end
        case (sel_i)
            caw_pkg::TB_DIV12: tick_o = (st_r.pre == caw_pkg::PRESCALE_LAST);
            caw_pkg::TB_DIV4: tick_o = (st_r.pre[1:0] == caw_pkg::FAST_LAST);
            caw_pkg::TB_TMR0: tick_o = tmr0_ovf_i;
            caw_pkg::TB_EXT_PIN: tick_o = pin_fall;
            caw_pkg::TB_SYSCLK: tick_o = 1'b1;
            caw_pkg::TB_EXT_OSC: tick_o = ext_osc_tick_i;
            default: tick_o = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '{pre: 4'h0, s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule // caw_timebase

// ### hdl/caw_watchdog.sv
// Notes on behaviour
// - enabled watchdog uses channel four compare bytes
// - watchdog enable bit resets to one
// - enabled watchdog keeps counter running, except while idle suspend pauses it
// - run bit reads software value only
// - counter byte writes ignored while enabled
// - other mode bits frozen while enabled
// - channel four forced timer mode, writes blocked
// - compare high write reloads count plus offset
// - low overflow with high match resets system
// - timeout equals 256*offset plus 256 minus low
// - writing one to channel four flag resets
// - enable or lock bit enables watchdog
// - lock holds enable until reset, else clearable
// - defaults: divide by 12, low zero, offset zero
// - run bit starts and stops counter, resets zero
// - overflow sets flag, irq when enabled
// - idle suspend bit pauses array during idle
// - high byte read returns low-read snapshot
// - compare low write clears, high sets enable
// - timer mode flags on full counter match
`timescale 1ns/1ps
module caw_watchdog (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic [7:0] SFR_WDATA_I,
    input wire logic SFR_WR_I,
    input wire logic SFR_RD_I,
    output logic [7:0] SFR_RDATA_O,
    input wire logic CPU_IDLE_I,
    input wire logic TMR0_OVF_I,
    input wire logic EXT_PIN_I,
    input wire logic EXT_OSC_TICK_I,
    output logic WDT_RESET_O,
    output logic IRQ_O,
    output logic WD_ENABLED_O,
    output logic CH0_WIDE_PWM_O
);
    localparam int N = caw_pkg::NUM_CH;
    localparam int W = caw_pkg::WD_CH;

    typedef struct packed {
        logic [15:0] cnt;
        logic [7:0] snap_high;
        logic run;
        logic ovf_flag;
        logic [N-1:0] match_flag;
        logic idle_suspend;
        logic wd_enable;
        logic wd_lock;
        logic [2:0] timebase;
        logic ovf_irq_en;
        logic [N-1:0][7:0] ch_mode;
        logic [N-1:0][7:0] cmp_low;
        logic [N-1:0][7:0] cmp_high;
        logic [7:0] rdata;
        logic wd_reset;
        logic irq;
    } caw_state_t;

    caw_state_t st_r;
    caw_state_t st_nxt;

    logic tick;
    logic wd_on;
    logic advance;
    logic [15:0] cnt_inc;
    logic low_wrap;
    logic [N-1:0] ch_mode_eff_cmp;
    logic [N-1:0] ch_mode_eff_match;
    logic [N-1:0] hw_match;
    logic [N-1:0] wr_mode;
    logic [N-1:0] wr_cmp_low;
    logic [N-1:0] wr_cmp_high;
    logic [N-1:0] rd_mode;
    logic [N-1:0] rd_cmp_low;
    logic [N-1:0] rd_cmp_high;
    logic wr_ctl;
    logic wr_md;
    logic wr_low;
    logic wr_high;
    logic rd_low;
    logic [7:0] rd_val;

    caw_timebase u_timebase (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .sel_i(st_r.timebase),
        .tmr0_ovf_i(TMR0_OVF_I),
        .ext_pin_i(EXT_PIN_I),
        .ext_osc_tick_i(EXT_OSC_TICK_I),
        .tick_o(tick)
    );

    assign wd_on = st_r.wd_enable | st_r.wd_lock;
    // counter forced on by the watchdog, idle suspend still applies
    assign advance = tick & (st_r.run | wd_on) & ~(st_r.idle_suspend & CPU_IDLE_I);
    assign cnt_inc = st_r.cnt + 16'h0001;
    assign low_wrap = advance & (st_r.cnt[7:0] == caw_pkg::BYTE_ALL_ONES);

    assign wr_ctl = SFR_WR_I & (SFR_ADDR_I == caw_pkg::ADDR_CONTROL);
    assign wr_md = SFR_WR_I & (SFR_ADDR_I == caw_pkg::ADDR_MODE);
    assign wr_low = SFR_WR_I & (SFR_ADDR_I == caw_pkg::ADDR_COUNT_LOW);
    assign wr_high = SFR_WR_I & (SFR_ADDR_I == caw_pkg::ADDR_COUNT_HIGH);
    assign rd_low = SFR_RD_I & (SFR_ADDR_I == caw_pkg::ADDR_COUNT_LOW);

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ch
            if (g == W) begin : g_wd
                // watchdog channel is pinned to software timer mode while the watchdog is on
                assign ch_mode_eff_cmp[g] = wd_on | st_r.ch_mode[g][caw_pkg::CM_CMP_EN];
                assign ch_mode_eff_match[g] = wd_on | st_r.ch_mode[g][caw_pkg::CM_MATCH_EN];
            end else begin : g_plain
                assign ch_mode_eff_cmp[g] = st_r.ch_mode[g][caw_pkg::CM_CMP_EN];
                assign ch_mode_eff_match[g] = st_r.ch_mode[g][caw_pkg::CM_MATCH_EN];
            end
            assign hw_match[g] = advance & ch_mode_eff_cmp[g] & ch_mode_eff_match[g]
                & (cnt_inc == {st_r.cmp_high[g], st_r.cmp_low[g]});
            assign wr_mode[g] = SFR_WR_I & (SFR_ADDR_I == caw_pkg::ADDR_CH_MODE[g]);
            assign wr_cmp_low[g] = SFR_WR_I & (SFR_ADDR_I == caw_pkg::ADDR_CH_CMP_LOW[g]);
            assign wr_cmp_high[g] = SFR_WR_I & (SFR_ADDR_I == caw_pkg::ADDR_CH_CMP_HIGH[g]);
            assign rd_mode[g] = (SFR_ADDR_I == caw_pkg::ADDR_CH_MODE[g]);
            assign rd_cmp_low[g] = (SFR_ADDR_I == caw_pkg::ADDR_CH_CMP_LOW[g]);
            assign rd_cmp_high[g] = (SFR_ADDR_I == caw_pkg::ADDR_CH_CMP_HIGH[g]);
        end
    endgenerate

    // read multiplexer
    always_comb begin
        rd_val = caw_pkg::BYTE_RESET;
        case (SFR_ADDR_I)
            caw_pkg::ADDR_CONTROL: begin
                // run bit shows software's own setting only
                rd_val = {st_r.ovf_flag, st_r.run, 1'b0, st_r.match_flag};
            end
            caw_pkg::ADDR_MODE: begin
                rd_val = {st_r.idle_suspend, st_r.wd_enable, st_r.wd_lock, 1'b0,
                    st_r.timebase, st_r.ovf_irq_en};
            end
            caw_pkg::ADDR_COUNT_LOW: rd_val = st_r.cnt[7:0];
            caw_pkg::ADDR_COUNT_HIGH: rd_val = st_r.snap_high;
            default: begin
                for (int i = 0; i < N; i++) begin
                    if (rd_mode[i]) begin
                        rd_val = st_r.ch_mode[i];
                    end
                    if (rd_cmp_low[i]) begin
                        rd_val = st_r.cmp_low[i];
                    end
                    if (rd_cmp_high[i]) begin
                        rd_val = st_r.cmp_high[i];
                    end
                end
            end
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.wd_reset = 1'b0;

        // counter advance; software load takes priority when allowed
        if (advance) begin
            st_nxt.cnt = cnt_inc;
        end
        if (!wd_on) begin
            if (wr_low) begin
                st_nxt.cnt[7:0] = SFR_WDATA_I;
            end
            if (wr_high) begin
                st_nxt.cnt[15:8] = SFR_WDATA_I;
            end
        end

        // low byte read freezes the high byte for a later read
        if (rd_low) begin
            st_nxt.snap_high = st_r.cnt[15:8];
        end

        // control register: software writes, hardware set wins
        if (wr_ctl) begin
            st_nxt.ovf_flag = SFR_WDATA_I[caw_pkg::CTL_OVF_FLAG];
            st_nxt.run = SFR_WDATA_I[caw_pkg::CTL_RUN];
            st_nxt.match_flag = SFR_WDATA_I[N-1:0];
            if (wd_on && SFR_WDATA_I[W]) begin
                st_nxt.wd_reset = 1'b1;
            end
        end
        if (advance && st_r.cnt == 16'hFFFF) begin
            st_nxt.ovf_flag = 1'b1;
        end
        st_nxt.match_flag = st_nxt.match_flag | hw_match;

        // mode register: only enable and lock may move while enabled
        if (wr_md) begin
            if (!wd_on) begin
                st_nxt.idle_suspend = SFR_WDATA_I[caw_pkg::MD_IDLE_SUSPEND];
                st_nxt.timebase = SFR_WDATA_I[caw_pkg::MD_TB_LSB +: 3];
                st_nxt.ovf_irq_en = SFR_WDATA_I[caw_pkg::MD_OVF_IRQ_EN];
            end
            if (!st_r.wd_lock) begin
                st_nxt.wd_enable = SFR_WDATA_I[caw_pkg::MD_WD_ENABLE];
            end
            // lock can only be set, sticky until system reset
            st_nxt.wd_lock = st_r.wd_lock | SFR_WDATA_I[caw_pkg::MD_WD_LOCK];
        end

        for (int i = 0; i < N; i++) begin
            if (wr_mode[i] && !(i == W && wd_on)) begin
                st_nxt.ch_mode[i] = SFR_WDATA_I;
            end
            if (wr_cmp_low[i]) begin
                st_nxt.cmp_low[i] = SFR_WDATA_I;
                st_nxt.ch_mode[i][caw_pkg::CM_CMP_EN] = 1'b0;
            end
            if (wr_cmp_high[i]) begin
                if (i == W && wd_on) begin
                    // refresh: written value discarded, deadline moved forward
                    // sum wraps within the byte, as the deadline byte does
                    st_nxt.cmp_high[i] = 8'(st_r.cnt[15:8] + st_r.cmp_low[i]);
                end else begin
                    st_nxt.cmp_high[i] = SFR_WDATA_I;
                end
                st_nxt.ch_mode[i][caw_pkg::CM_CMP_EN] = 1'b1;
            end
        end

        // deadline hit: high matches while the low byte wraps
        if (wd_on && low_wrap && st_r.cmp_high[W] == st_r.cnt[15:8]) begin
            st_nxt.wd_reset = 1'b1;
        end

        if (SFR_RD_I) begin
            st_nxt.rdata = rd_val;
        end

        st_nxt.irq = (st_nxt.ovf_flag & st_nxt.ovf_irq_en);
        for (int i = 0; i < N; i++) begin
            if (st_nxt.match_flag[i] && st_nxt.ch_mode[i][caw_pkg::CM_IRQ_EN]) begin
                st_nxt.irq = 1'b1;
            end
        end
    end

    // every reset comes back with the watchdog armed
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_r <= '0;
            st_r.wd_enable <= caw_pkg::MODE_RESET[caw_pkg::MD_WD_ENABLE];
            st_r.timebase <= caw_pkg::TB_DIV12;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign SFR_RDATA_O = st_r.rdata;
    assign WDT_RESET_O = st_r.wd_reset;
    assign IRQ_O = st_r.irq;
    assign WD_ENABLED_O = wd_on;
    assign CH0_WIDE_PWM_O = st_r.ch_mode[0][caw_pkg::CM_WIDE_PWM];

endmodule // caw_watchdog

// ### tb/caw_watchdog_assertions.sv
`timescale 1ns/1ps
module caw_watchdog_assertions (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic [7:0] SFR_WDATA_I,
    input wire logic SFR_WR_I,
    input wire logic SFR_RD_I,
    input wire logic [7:0] SFR_RDATA_O,
    input wire logic WDT_RESET_O,
    input wire logic WD_ENABLED_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    logic lock_r;
    logic run_r;
    wire logic ctl_wr = SFR_WR_I && SFR_ADDR_I == 8'hD8;
    wire logic md_wr = SFR_WR_I && SFR_ADDR_I == 8'hD9;
    wire logic rd_only = SFR_RD_I && !SFR_WR_I;
    // shadow of software writes; lock sticky until reset
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            lock_r <= 1'b0;
            run_r <= 1'b0;
        end else begin
            if (md_wr && SFR_WDATA_I[5]) lock_r <= 1'b1;
            if (ctl_wr) run_r <= SFR_WDATA_I[6];
        end
    end
    property p_wake_on; $rose(RST_N_I) |-> WD_ENABLED_O; endproperty
    a_wake_on: assert property (p_wake_on)
        else $error("watchdog off after reset");
    property p_force; ctl_wr && SFR_WDATA_I[4] && WD_ENABLED_O |=> WDT_RESET_O; endproperty
    a_force: assert property (p_force)
        else $error("forced reset missing");
    property p_quiet; !WD_ENABLED_O |=> !WDT_RESET_O; endproperty
    a_quiet: assert property (p_quiet)
        else $error("reset while disabled");
    property p_cause; WDT_RESET_O |-> $past(WD_ENABLED_O); endproperty
    a_cause: assert property (p_cause)
        else $error("reset without enabled watchdog");
    property p_locked; lock_r |-> WD_ENABLED_O; endproperty
    a_locked: assert property (p_locked)
        else $error("locked watchdog disabled");
    property p_unlock; md_wr && SFR_WDATA_I[6:5] == 2'b00 && !lock_r |=> !WD_ENABLED_O;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("disable ignored");
    property p_run_rd; rd_only && SFR_ADDR_I == 8'hD8 && !run_r |=> !SFR_RDATA_O[6];
    endproperty
    a_run_rd: assert property (p_run_rd)
        else $error("run bit reads one");
    property p_mode_rd;
        rd_only && SFR_ADDR_I == 8'hD9 && WD_ENABLED_O |=> SFR_RDATA_O[6:5] != 2'b00;
    endproperty
    a_mode_rd: assert property (p_mode_rd)
        else $error("mode read hides enable");
    c_timeout: cover property (WDT_RESET_O);
    c_lock: cover property (lock_r);
    c_run: cover property (run_r);
endmodule // caw_watchdog_assertions
bind caw_watchdog caw_watchdog_assertions u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .SFR_ADDR_I(SFR_ADDR_I), .SFR_WDATA_I(SFR_WDATA_I), .SFR_WR_I(SFR_WR_I),
    .SFR_RD_I(SFR_RD_I), .SFR_RDATA_O(SFR_RDATA_O), .WDT_RESET_O(WDT_RESET_O),
    .WD_ENABLED_O(WD_ENABLED_O));

// ### tb/caw_watchdog_tb.sv
`timescale 1ns/1ps
module caw_watchdog_tb;
    logic CLK_I = 0;
    logic RST_N_I = 0;
    logic SFR_WR_I = 0;
    logic SFR_RD_I = 0;
    logic [7:0] SFR_ADDR_I = 0;
    logic [7:0] SFR_WDATA_I = 0;
    logic CPU_IDLE_I = 0;
    logic [7:0] SFR_RDATA_O;
    logic WDT_RESET_O, IRQ_O, WD_ENABLED_O, CH0_WIDE_PWM_O, rd_d;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    logic [7:0] lo, off;
    int fail_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int t0 = 0;
    int want;
    always #20 CLK_I = ~CLK_I;
    caw_watchdog uut (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .SFR_ADDR_I(SFR_ADDR_I),
        .SFR_WDATA_I(SFR_WDATA_I), .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I),
        .SFR_RDATA_O(SFR_RDATA_O), .CPU_IDLE_I(CPU_IDLE_I), .TMR0_OVF_I(1'b0),
        .EXT_PIN_I(1'b1), .EXT_OSC_TICK_I(1'b0), .WDT_RESET_O(WDT_RESET_O),
        .IRQ_O(IRQ_O), .WD_ENABLED_O(WD_ENABLED_O), .CH0_WIDE_PWM_O(CH0_WIDE_PWM_O));
    // run is about 4000 cycles, so this only trips on a hang
    always @(posedge CLK_I) begin
        rd_d <= SFR_RD_I;
        cyc <= cyc + 1;
        if (cyc > 8000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t read %h want %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    // read data settles one cycle after the strobe
    always @(negedge CLK_I) begin
        if (rd_d === 1'b1) begin
            e = exp_q.pop_front();
            chk8(SFR_RDATA_O & e[15:8], e[7:0]);
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK_I);
        SFR_ADDR_I = a;
        SFR_WDATA_I = d;
        SFR_WR_I = 1;
        @(negedge CLK_I);
        SFR_WR_I = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        @(negedge CLK_I);
        SFR_ADDR_I = a;
        SFR_RD_I = 1;
        exp_q.push_back({m, exp & m});
        @(negedge CLK_I);
        SFR_RD_I = 0;
    endtask
    task automatic do_reset();
        @(negedge CLK_I);
        RST_N_I = 0;
        repeat (3) @(negedge CLK_I);
        RST_N_I = 1;
        t0 = cyc;
    endtask
    // device never resets itself, so the bench does it on the pulse
    task automatic wait_rst(input int lo_c, input int hi_c, input string s);
        int n;
        n = 0;
        while (WDT_RESET_O !== 1'b1 && n < 4000) begin
            @(negedge CLK_I);
            n++;
        end
        chkb(cyc - t0 >= lo_c && cyc - t0 <= hi_c, 1'b1, "reset timing");
        do_reset();
        $display("test %s done", s);
    endtask
    task automatic stop_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        void'($urandom(33));
        do_reset();
        rd(8'hD9, 8'h40, 8'hFF);
        rd(8'hD8, 8'h00, 8'hFF);
        rd(8'(8'h00 + $urandom % 16), 8'h00, 8'hFF);
        wr(8'hFA, 8'(1 + $urandom % 200));
        wr(8'hF9, 8'hF0);
        rd(8'hF9, 8'h00, 8'h00);
        rd(8'hFA, 8'h00, 8'hFF);
        want = 256 * caw_pkg::PRESCALE_SLOW;
        wait_rst(want - 2, want + 14, "default timeout");
        t0 = cyc;
        wr(8'hD8, 8'h10);
        wait_rst(0, 4, "forced reset");
        off = 8'(1 + $urandom % 2);
        lo = 8'hF0 | 8'($urandom % 8);
        wr(8'hD9, 8'h00);
        chkb(WD_ENABLED_O, 1'b0, "disable");
        wr(8'hD9, 8'h08);
        rd(8'hD9, 8'h08, 8'hFF);
        wr(8'hED, off);
        wr(8'hF9, lo);
        rd(8'hF9, lo, 8'hFF);
        wr(8'hD9, 8'h48);
        t0 = cyc;
        wr(8'hEE, 8'h00);
        want = 256 * off + 256 - lo;
        wait_rst(want - 3, want + 5, "offset timeout");
        wr(8'hD9, 8'h60);
        wr(8'hD9, 8'h00);
        chkb(WD_ENABLED_O, 1'b1, "lock");
        wr(8'hD9, 8'h63);
        rd(8'hD9, 8'h60, 8'hFF);
        do_reset();
        wr(8'hD9, 8'h00);
        wr(8'h D9, 8'h89);
        CPU_IDLE_I = 1;
        wr(8'hF9, 8'hFE);
        wr(8'hFA, 8'hFF);
        wr(8'hD8, 8'h40);
        repeat (4) @(negedge CLK_I);
        // idle with suspend set: counter must hold
        rd(8'hF9, 8'hFE, 8'hFF);
        CPU_IDLE_I = 0;
        repeat (4) @(negedge CLK_I);
        chkb(IRQ_O, 1'b1, "overflow irq");
        rd(8'hD8, 8'hC0, 8'hC0);
        wr(8'hD8, 8'h00);
        repeat (2) @(negedge CLK_I);
        chkb(IRQ_O, 1'b0, "irq clear");
        wr(8'hDA, 8'h80);
        rd(8'hDA, 8'h80, 8'hFF);
        chkb(CH0_WIDE_PWM_O, 1'b1, "wide pwm");
        $display("test counting done");
        repeat (2) @(negedge CLK_I);
        stop_test();
    end
endmodule // caw_watchdog_tb
